// ==== rtl/hsc_i2c_port.v ====
// Two-wire slave command port of the humidity and temperature sensor.
// Assumes a single master, open-drain lines resolved outside, and a
// measurement engine that gives calibrated 14-bit words with meas_done.
`timescale 1ns/1ps
`include "hsc_consts.vh"

// Behaviour
// RULE1: Slave only, works at 100k and 400k
// RULE2: Single master assumed on shared bus
// RULE3: Master frames with START and STOP
// RULE4: Answer only address 0x54
// RULE5: Sample SDA rising SCL, hold while high
// RULE6: Direction bit: 1 read, 0 write
// RULE7: Eight bits then acknowledge bit
// RULE8: Master continues or stops after ack
// RULE9: Temperature commands return two bytes, CRC
// RULE10: Humidity commands return four bytes, CRC
// RULE11: Decode register read and write commands
// RULE12: Decode stop-periodic and read-ID commands
// RULE13: Results pass through already compensated
// RULE14: Hold commands stretch SCL until done
// RULE15: No-hold read nacked while converting
// RULE16: Readings shifted out MSB first
// RULE17: CRC-8 0x1d seed 0xff over four bytes
// RULE18: Unknown command bytes are nacked, ignored
module hsc_i2c_port #(
  parameter [6:0] SLAVE_ADDR = `HSC_SLAVE_ADDR,
  parameter [7:0] ID_BYTE = 8'h5a // Arbitrary identity value
) (
  input wire clk,
  input wire rst,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  output reg meas_start_q,
  output reg meas_humid_q,
  input wire meas_done,
  input wire [13:0] humid_word,
  input wire [13:0] temp_word,
  output reg reg_rd_q,
  output reg reg_wr_q,
  output reg stop_periodic_q,
  output reg [7:0] wr_data_q,
  output reg wr_data_vld_q,
  input wire [7:0] reg_rd_data,
  output reg busy_q
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages, change when stages 2 and 3 agree
  reg [2:0] scl_sync_q;
  reg [2:0] sda_sync_q;
  reg scl_q;
  reg sda_q;
  always @(posedge clk) begin
    if (rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
    end
  end
  wire scl_next = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
  wire sda_next = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
  wire scl_rise = scl_next & ~scl_q;
  wire scl_fall = ~scl_next & scl_q;
  // Oversampling gives margin at 400 kHz; no edge rate limit inside
  wire start_det = scl_q & scl_next & sda_q & ~sda_next; // RULE3
  wire stop_det = scl_q & scl_next & ~sda_q & sda_next; // RULE3

  ////////////////////////////////////////////////////////////////////
  // Protocol state
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_RXB = 3'h3;
  localparam [2:0] ST_TXB = 3'h4;
  localparam [2:0] ST_MACK = 3'h5;
  localparam [2:0] ST_STRETCH = 3'h6;

  localparam [2:0] CM_NONE = 3'h0;
  localparam [2:0] CM_MEAS = 3'h1;
  localparam [2:0] CM_RDREG = 3'h2;
  localparam [2:0] CM_WRREG = 3'h3;
  localparam [2:0] CM_ID = 3'h4;

  reg [2:0] state_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg ack_drv_q;
  reg tx_bit_q;
  reg tx_en_q;
  reg first_q;
  reg rd_dir_q;
  reg [2:0] cmd_q;
  reg hold_q;
  reg meas_pend_q;
  reg res_rdy_q;
  reg [39:0] out_q;
  reg [2:0] bytes_left_q;
  reg [7:0] crc_q;
  reg [1:0] crc_step_q;
  reg stretch_q;

  ////////////////////////////////////////////////////////////////////
  // CRC over humidity then temperature, humidity zero for temp only
  reg [7:0] crc_byte;
  wire [7:0] crc_nxt;
  always @* begin
    case (crc_step_q)
      2'h0: crc_byte = meas_humid_q ? {2'h0, humid_word[13:8]} : 8'h00;
      2'h1: crc_byte = meas_humid_q ? humid_word[7:0] : 8'h00;
      2'h2: crc_byte = {2'h0, temp_word[13:8]};
      default: crc_byte = temp_word[7:0];
    endcase
  end
  hsc_crc8 #(
    .POLY(`HSC_CRC_POLY)
  ) i_hsc_crc8 (
    .crc_in(crc_q),
    .data_in(crc_byte),
    .crc_out(crc_nxt)
  ); // RULE17

  reg crc_run_q;

  ////////////////////////////////////////////////////////////////////
  // Command decode
  reg [2:0] dec_cmd;
  reg dec_ok;
  reg dec_hold;
  reg dec_humid;
  always @* begin
    dec_cmd = CM_NONE;
    dec_ok = 1'b1;
    dec_hold = 1'b0;
    dec_humid = 1'b0;
    case (sh_q)
      `HSC_CMD_T_HOLD: begin
        dec_cmd = CM_MEAS;
        dec_hold = 1'b1; // RULE9
      end
      `HSC_CMD_T_NOHOLD: dec_cmd = CM_MEAS; // RULE9
      `HSC_CMD_HT_HOLD: begin
        dec_cmd = CM_MEAS;
        dec_hold = 1'b1;
        dec_humid = 1'b1; // RULE10
      end
      `HSC_CMD_HT_NOHOLD: begin
        dec_cmd = CM_MEAS;
        dec_humid = 1'b1; // RULE10
      end
      `HSC_CMD_REG_RD: dec_cmd = CM_RDREG; // RULE11
      `HSC_CMD_REG_WR: dec_cmd = CM_WRREG; // RULE11
      `HSC_CMD_STOP_PER: dec_cmd = CM_NONE; // RULE12
      `HSC_CMD_READ_ID: dec_cmd = CM_ID; // RULE12
      default: dec_ok = 1'b0; // RULE18
    endcase
  end

  wire addr_match = (sh_q[7:1] == SLAVE_ADDR); // RULE4
  wire addr_read = (sh_q[0] == `HSC_DIR_READ); // RULE6
  wire read_ready = (cmd_q != CM_MEAS) | res_rdy_q;

  ////////////////////////////////////////////////////////////////////
  // Main sequencer
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ack_drv_q <= 1'b0;
      tx_bit_q <= 1'b1;
      tx_en_q <= 1'b0;
      first_q <= 1'b0;
      rd_dir_q <= 1'b0;
      cmd_q <= CM_NONE;
      hold_q <= 1'b0;
      meas_pend_q <= 1'b0;
      res_rdy_q <= 1'b0;
      out_q <= 40'h0;
      bytes_left_q <= 3'h0;
      crc_q <= `HSC_CRC_INIT;
      crc_step_q <= 2'h0;
      crc_run_q <= 1'b0;
      stretch_q <= 1'b0;
      meas_start_q <= 1'b0;
      meas_humid_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      stop_periodic_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_data_vld_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      meas_start_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      stop_periodic_q <= 1'b0;
      wr_data_vld_q <= 1'b0;
      busy_q <= (state_q != ST_IDLE);
      // Result capture; CRC walks four bytes over four cycles
      if (meas_pend_q && meas_done) begin
        meas_pend_q <= 1'b0;
        crc_run_q <= 1'b1;
        crc_step_q <= 2'h0;
        crc_q <= `HSC_CRC_INIT; // RULE17
      end
      if (crc_run_q) begin
        crc_q <= crc_nxt; // RULE17
        crc_step_q <= crc_step_q + 2'h1;
        if (crc_step_q == 2'h3) begin
          crc_run_q <= 1'b0;
          res_rdy_q <= 1'b1;
          // Words pass untouched; the engine already compensates
          if (meas_humid_q) begin
            out_q <= {2'h0, humid_word, 2'h0, temp_word, crc_nxt}; // RULE13
          end else begin
            out_q <= {2'h0, temp_word, crc_nxt, 16'h0000}; // RULE13
          end
        end
      end
      if (stretch_q && res_rdy_q) begin
        stretch_q <= 1'b0; // RULE14
      end
      if (start_det) begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
        tx_en_q <= 1'b0;
        ack_drv_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        tx_en_q <= 1'b0;
        ack_drv_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_RXB: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_q}; // RULE5
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'h8) begin // RULE7
              bit_q <= 4'h0;
              state_q <= ST_ACK;
              if (state_q == ST_ADDR) begin
                first_q <= 1'b1;
                if (!addr_match) begin
                  state_q <= ST_IDLE; // RULE4
                end else if (!addr_read) begin
                  rd_dir_q <= 1'b0;
                  ack_drv_q <= 1'b1;
                  cmd_q <= CM_NONE;
                end else if (read_ready) begin
                  rd_dir_q <= 1'b1;
                  ack_drv_q <= 1'b1;
                  res_rdy_q <= 1'b0;
                  bytes_left_q <= meas_humid_q ? 3'h5 : 3'h3; // RULE9 RULE10
                end else if (hold_q) begin
                  rd_dir_q <= 1'b1;
                  ack_drv_q <= 1'b1;
                  stretch_q <= 1'b1; // RULE14
                  bytes_left_q <= meas_humid_q ? 3'h5 : 3'h3;
                end else begin
                  state_q <= ST_IDLE; // RULE15
                end
              end else if (first_q && cmd_q == CM_NONE) begin
                first_q <= 1'b0;
                ack_drv_q <= dec_ok; // RULE18
                if (dec_ok) begin
                  cmd_q <= dec_cmd;
                  if (dec_cmd == CM_MEAS) begin
                    meas_start_q <= 1'b1;
                    meas_humid_q <= dec_humid;
                    hold_q <= dec_hold;
                    meas_pend_q <= 1'b1;
                    res_rdy_q <= 1'b0;
                  end
                  reg_rd_q <= (dec_cmd == CM_RDREG);
                  stop_periodic_q <= (sh_q == `HSC_CMD_STOP_PER);
                end
              end else begin
                ack_drv_q <= 1'b1;
                wr_data_q <= sh_q;
                wr_data_vld_q <= 1'b1;
                reg_wr_q <= (cmd_q == CM_WRREG);
              end
            end
          end
          ST_ACK: begin
            // Acknowledge bit driven through the whole ninth clock
            if (scl_fall && !stretch_q) begin
              ack_drv_q <= 1'b0;
              if (rd_dir_q) begin
                state_q <= ST_TXB;
                if (cmd_q == CM_MEAS) begin
                  sh_q <= out_q[39:32];
                  tx_bit_q <= out_q[39];
                end else if (cmd_q == CM_ID) begin
                  sh_q <= ID_BYTE;
                  tx_bit_q <= ID_BYTE[7];
                  bytes_left_q <= 3'h1;
                end else begin
                  sh_q <= reg_rd_data;
                  tx_bit_q <= reg_rd_data[7];
                  bytes_left_q <= 3'h1;
                end
                tx_en_q <= 1'b1;
                out_q <= {out_q[31:0], 8'h00};
              end else begin
                state_q <= ST_RXB;
              end
            end
          end
          ST_TXB: begin
            if (scl_fall) begin
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[6:0], 1'b0};
              tx_bit_q <= sh_q[6]; // RULE16
              if (bit_q == 4'h7) begin
                bit_q <= 4'h0;
                tx_en_q <= 1'b0;
                bytes_left_q <= bytes_left_q - 3'h1;
                state_q <= ST_MACK;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              sh_q <= out_q[39:32];
              if (sda_q == `HSC_NACK || bytes_left_q == 3'h0) begin
                state_q <= ST_IDLE;
              end
            end
            if (scl_fall) begin
              state_q <= ST_TXB;
              tx_bit_q <= sh_q[7];
              tx_en_q <= 1'b1;
              out_q <= {out_q[31:0], 8'h00};
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Open-drain drive: enable high while pulling the line low
  assign sda_o = 1'b0;
  assign sda_oe = ack_drv_q | (tx_en_q & ~tx_bit_q); // RULE7
  assign scl_o = 1'b0;
  assign scl_oe = stretch_q & ~scl_q; // RULE14 RULE1

endmodule

// ==== include/hsc_consts.vh ====
// Constants for the humidity sensor two-wire command port.
// Assumes inclusion by bare name from the rtl files.
`ifndef HSC_CONSTS_VH
`define HSC_CONSTS_VH
`define HSC_SLAVE_ADDR 7'h54
`define HSC_CMD_T_HOLD 8'he3
`define HSC_CMD_T_NOHOLD 8'hf3
`define HSC_CMD_HT_HOLD 8'he5
`define HSC_CMD_HT_NOHOLD 8'hf5
`define HSC_CMD_REG_RD 8'ha7
`define HSC_CMD_REG_WR 8'ha6
`define HSC_CMD_STOP_PER 8'h30
`define HSC_CMD_READ_ID 8'hd7
`define HSC_CRC_POLY 8'h1d
`define HSC_CRC_INIT 8'hff
`define HSC_DIR_READ 1'b1
`define HSC_ACK 1'b0
`define HSC_NACK 1'b1
`define HSC_MIN_SCL_KHZ 100
`define HSC_MAX_SCL_KHZ 400
`define HSC_HOLD_MIN_SCL_KHZ 200
`define HSC_CLK_MHZ 100
`define HSC_T_LOW_NS 600
`define HSC_T_LOW_CYC ((`HSC_T_LOW_NS * `HSC_CLK_MHZ + 999) / 1000)
`define HSC_T_HDDAT_MAX_NS 500
`define HSC_T_HDDAT_CYC ((`HSC_T_HDDAT_MAX_NS * `HSC_CLK_MHZ) / 1000)
`endif

// ==== rtl/hsc_crc8.v ====
// Byte-wide CRC-8 step, polynomial 0x1d, MSB first.
// Assumes the caller holds the running value and seeds it.
`timescale 1ns/1ps
module hsc_crc8 #(
  parameter [7:0] POLY = 8'h1d
) (
  input wire [7:0] crc_in,
  input wire [7:0] data_in,
  output reg [7:0] crc_out
);
  integer i;
  reg [7:0] c;
  always @* begin
    c = crc_in ^ data_in;
    for (i = 0; i < 8; i = i + 1) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule

// ==== verif/hsc_i2c_port_chk.sv ====
// Checker for the two-wire command port; sees only the port's pins.
// Assumes one clock, rst synchronous and active high.
`timescale 1ns/1ps
module hsc_i2c_port_chk (
  input wire clk,
  input wire rst,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_oe,
  input wire sda_o,
  input wire meas_start_q,
  input wire meas_done,
  input wire reg_rd_q,
  input wire reg_wr_q,
  input wire stop_periodic_q,
  input wire wr_data_vld_q,
  input wire busy_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_pins_low; !scl_o && !sda_o; endproperty
  a_pins_low: assert property (p_pins_low)
    else $error("pin driven high");
  property p_sda_grab; $rose(sda_oe) |-> !scl_i; endproperty
  a_sda_grab: assert property (p_sda_grab)
    else $error("sda taken while scl high");
  property p_sda_hold; scl_i && $past(scl_i) |-> $stable(sda_oe); endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("sda moved while scl high");
  property p_meas_pulse; meas_start_q |=> !meas_start_q; endproperty
  a_meas_pulse: assert property (p_meas_pulse)
    else $error("measure start too long");
  property p_rd_pulse; reg_rd_q |=> !reg_rd_q; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("register read too long");
  property p_wr_vld; reg_wr_q |-> wr_data_vld_q; endproperty
  a_wr_vld: assert property (p_wr_vld)
    else $error("register write without data");
  property p_cmd_excl; $onehot0({meas_start_q, reg_rd_q, stop_periodic_q, reg_wr_q}); endproperty
  a_cmd_excl: assert property (p_cmd_excl)
    else $error("two commands at once");
  property p_stop_pulse; stop_periodic_q |=> !stop_periodic_q; endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop request too long");
  property p_stretch_end; meas_done && scl_oe |-> ##[1:40] !scl_oe; endproperty
  a_stretch_end: assert property (p_stretch_end)
    else $error("scl held after result");
  property p_stretch_low; $rose(scl_oe) |-> !$past(scl_i) && busy_q; endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("stretch began badly");
endmodule
bind hsc_i2c_port hsc_i2c_port_chk i_chk (.clk(clk), .rst(rst), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .sda_o(sda_o), .meas_start_q(meas_start_q),
  .meas_done(meas_done), .reg_rd_q(reg_rd_q), .reg_wr_q(reg_wr_q),
  .stop_periodic_q(stop_periodic_q), .wr_data_vld_q(wr_data_vld_q), .busy_q(busy_q));

// ==== verif/hsc_master.sv ====
// Behavioural single bus master at 400 kHz, driving open-drain enables.
// Assumes the bench resolves the wires with pull-ups.
`timescale 1ns/1ps
module hsc_master (
  input wire clk,
  input wire scl,
  input wire sda,
  output logic scl_oe,
  output logic sda_oe
);
  localparam int HP = 125;
  initial begin
    scl_oe = 0;
    sda_oe = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task hp;
    repeat (HP) @(posedge clk);
    #1;
  endtask
  // Waits out a stretched clock, bounded so a stuck slave cannot hang us
  task rise(output logic r);
    int n;
    scl_oe = 0;
    n = 0;
    while (scl !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    r = sda;
    hp;
  endtask
  task bitx(input logic b, output logic r);
    sda_oe = !b;
    hp;
    rise(r);
    scl_oe = 1;
  endtask
  task start;
    sda_oe = 1;
    hp;
    scl_oe = 1;
  endtask
  task stop;
    logic r;
    sda_oe = 1;
    hp;
    rise(r);
    sda_oe = 0;
    hp;
  endtask
  task xfer(input [7:0] d, input logic ai, output [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ai, ao);
  endtask
endmodule

// ==== verif/hsc_i2c_port_tb.sv ====
// Self-checking bench: command port, bus master model, result source.
// Assumes hsc_consts.vh on the include path.
`timescale 1ns/1ps
module hsc_i2c_port_tb;
  localparam [7:0] ID = 8'h5a; // Arbitrary identity value
  logic clk, rst, meas_done, stretched, a, h, hold;
  logic [13:0] humid_word, temp_word;
  logic [7:0] reg_rd_data, q, c;
  logic [31:0] r, e;
  wire scl_oe, sda_oe, scl_o, sda_o, m_scl_oe, m_sda_oe, meas_start_q, meas_humid_q;
  wire reg_rd_q, reg_wr_q, stop_periodic_q, wr_data_vld_q, busy_q;
  wire [7:0] wr_data_q;
  wire scl = !(scl_oe | m_scl_oe);
  wire sda = !(sda_oe | m_sda_oe);
  integer seed = 451;
  int num_errors, compares;
  int cnt [4];
  hsc_i2c_port #(.ID_BYTE(ID)) i_hsc_i2c_port (.clk(clk), .rst(rst), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .meas_start_q(meas_start_q),
    .meas_humid_q(meas_humid_q), .meas_done(meas_done), .humid_word(humid_word),
    .temp_word(temp_word), .reg_rd_q(reg_rd_q), .reg_wr_q(reg_wr_q),
    .stop_periodic_q(stop_periodic_q), .wr_data_q(wr_data_q), .wr_data_vld_q(wr_data_vld_q),
    .reg_rd_data(reg_rd_data), .busy_q(busy_q));
  hsc_master i_hsc_master (.clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cnt[0] += (meas_start_q === 1'b1);
    cnt[1] += (reg_rd_q === 1'b1);
    cnt[2] += (reg_wr_q === 1'b1);
    cnt[3] += (stop_periodic_q === 1'b1);
    if (scl_oe === 1'b1) stretched = 1;
  end
  // Conversion finishes shortly after the first read address arrives
  initial forever begin
    @(posedge clk);
    #1;
    if (meas_start_q === 1'b1) begin
      repeat (3000) @(posedge clk);
      #1 meas_done = 1;
      @(posedge clk);
      #1 meas_done = 0;
    end
  end
  function [7:0] crc(input [31:0] d);
    logic [7:0] v;
    v = 8'hff;
    for (int i = 31; i >= 0; i--) v = {v[6:0], 1'b0} ^ ((v[7] ^ d[i]) ? 8'h1d : 8'h00);
    return v;
  endfunction
  task chk(input [15:0] seen, input [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tx(input [7:0] d, input logic ea);
    i_hsc_master.xfer(d, 1'b1, q, a);
    chk(a, ea, "ack");
  endtask
  task rx(input [7:0] ed, input logic last);
    i_hsc_master.xfer(8'hff, last, q, a);
    chk(q, ed, "rdata");
  endtask
  task cmd(input [7:0] cc, input logic ea);
    i_hsc_master.start;
    tx(8'ha8, 0);
    tx(cc, ea);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Scenarios need about 115k cycles at 400 kHz; margin for stretches
  initial begin
    #1300000;
    num_errors++;
    wrap_up;
  end
  initial begin
    rst = 1;
    meas_done = 0;
    humid_word = 0;
    temp_word = 0;
    reg_rd_data = 0;
    stretched = 0;
    repeat (16) @(posedge clk);
    #1 rst = 0;
    repeat (8) @(posedge clk);
    #1;
    r = $random(seed);
    i_hsc_master.start;
    tx({7'h54 ^ (r[6:0] | 7'h01), 1'b0}, 1);
    i_hsc_master.stop;
    cmd(8'h12, 1);
    i_hsc_master.stop;
    chk(cnt[0] + cnt[1] + cnt[2] + cnt[3], 0, "pulses");
    cmd(8'h30, 0);
    i_hsc_master.stop;
    chk(cnt[3], 1, "stop pulses");
    $display("test address and decode done");
    cmd(8'ha6, 0);
    tx(r[15:8], 0);
    i_hsc_master.stop;
    chk(wr_data_q, r[15:8], "wdata");
    chk(cnt[2], 1, "write pulses");
    $display("test write commands done");
    for (int k = 0; k < 2; k++) begin
      reg_rd_data = r[23:16];
      cmd(k ? 8'hd7 : 8'ha7, 0);
      i_hsc_master.stop;
      i_hsc_master.start;
      tx(8'ha9, 0);
      rx(k ? ID : r[23:16], 1);
      i_hsc_master.stop;
    end
    chk(cnt[1], 1, "read pulses");
    $display("test read commands done");
    for (int k = 0; k < 4; k++) begin
      c = k[1] ? (k[0] ? 8'he5 : 8'he3) : (k[0] ? 8'hf5 : 8'hf3);
      r = $random(seed);
      humid_word = (c == 8'hf5) ? 14'h0580 : r[13:0];
      temp_word = (c == 8'hf5) ? 14'h0580 : r[27:14];
      h = c[2];
      hold = !c[4];
      stretched = 0;
      cmd(c, 0);
      i_hsc_master.stop;
      i_hsc_master.start;
      if (!hold) begin
        tx(8'ha9, 1);
        i_hsc_master.stop;
        repeat (100) @(posedge clk);
        #1;
        i_hsc_master.start;
      end
      tx(8'ha9, 0);
      e = {2'b00, h ? humid_word : 14'h0, 2'b00, temp_word};
      if (h) rx(e[31:24], 0);
      if (h) rx(e[23:16], 0);
      rx(e[15:8], 0);
      rx(e[7:0], 0);
      rx((c == 8'hf5) ? 8'hf2 : crc(e), 1);
      i_hsc_master.stop;
      chk(meas_humid_q, h, "humid mode");
      chk(stretched, hold, "stretch");
      chk(cnt[0], k + 1, "meas pulses");
      $display("test measure %h done", c);
    end
    wrap_up;
  end
endmodule
